// >>> emb_cfg.svh
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH

// Register byte offsets on the Wishbone slave
`define EMB_ADR_CTRL      8'h00
`define EMB_ADR_OPTS      8'h04
`define EMB_ADR_STATUS    8'h08
`define EMB_ADR_LOAD_ADDR 8'h0C
`define EMB_ADR_LOAD_DATA 8'h10
`define EMB_ADR_LINES     8'h14

// Control register fields
`define EMB_CTRL_MODE_LSB  0
`define EMB_CTRL_WSELA_LSB 2
`define EMB_CTRL_WSELB_LSB 5
`define EMB_CTRL_CMODE_LSB 8
`define EMB_CTRL_ENC_BIT   10

// Path register option bits
`define EMB_OPT_WDATA 0
`define EMB_OPT_RDATA 1
`define EMB_OPT_RADDR 2
`define EMB_OPT_WADDR 3
`define EMB_OPT_WE    4
`define EMB_OPT_RE    5

// Reset values
`define EMB_CTRL_RST 32'h0000_0000
`define EMB_OPTS_RST 6'h3D

// Geometry
`define EMB_MEM_BITS   4096
`define EMB_HALF_BITS  2048
`define EMB_CAM_WORDS  32
`define EMB_CAM_WIDTH  32
`define EMB_FAST_WORDS 16
`define EMB_MAX_WSEL   3'h4
`define EMB_ROM_WSEL   3'h3

`endif

// >>> emb_pkg.sv
package emb_pkg;

	// Memory organisation
	typedef enum logic [1:0] {EMB_DUAL, EMB_SPLIT, EMB_ROM, EMB_CAM} emb_mode_t;

	// Match output style
	typedef enum logic [1:0] {EMB_SINGLE, EMB_MULTI, EMB_FAST, EMB_CM_RSVD} emb_cmode_t;

	// Match-table write sequence
	typedef enum logic [1:0] {EMB_CW_IDLE, EMB_CW_DATA, EMB_CW_COMMIT, EMB_CW_CARE} emb_cw_t;

	typedef struct packed {
		emb_mode_t          mode;
		logic [1:0][2:0]    wsel;
		emb_cmode_t         cmode;
		logic               enc;
		logic [5:0]         opts;
		logic [7:0]         ld_idx;
		logic               ack;
		logic [31:0]        dat;
		logic [1:0][15:0]   wd;
		logic [1:0][11:0]   wa;
		logic [1:0][11:0]   ra;
		logic [1:0]         we;
		logic [1:0]         re;
		logic [1:0][15:0]   rd1;
		logic [1:0][15:0]   rd2;
		emb_cw_t            cw;
		logic [4:0]         cw_addr;
		logic [31:0]        cw_data;
		logic [31:0]        cw_care;
		logic               cw_care_en;
		logic [31:0]        hits;
		logic               pend;
		logic               match;
		logic [4:0]         maddr;
		logic [15:0]        lines;
		logic               valid;
		logic               phase;
		logic [4095:0]      mem;
		logic [1023:0]      care;
	} emb_state_t;

endpackage

// >>> emb_memory_block.sv
// Summary of operation
// [RULE1] Input registers and output registers separately enabled
// [RULE2] Each port: read, write enables and clear
// [RULE3] Registers cleared by local, global, chip reset
// [RULE4] Split mode hosts two single-port RAMs
// [RULE5] Parallel compare gives address and match flag
// [RULE6] Match table holds 32 words of 32 bits
// [RULE7] Don't-care bits ignored during comparison
// [RULE8] Single, multiple, fast modes; encoded or lines
// [RULE9] Sixteen lines per port, two cycles
// [RULE10] Unencoded compare uses 31 bits, one selects
// [RULE11] Select one gives odd words, zero even
// [RULE12] Single: two-cycle write, one-cycle lookup
// [RULE13] Multiple: two-cycle write, two-cycle report
// [RULE14] Fast: one cycle, sixteen words deep
// [RULE15] Preload or runtime write, two/three cycles
// [RULE16] Each path register selectable on its own
// [RULE17] ROM mode: preloaded lookup table, no writes
// [RULE18] RAM widths 1,2,4,8,16 bits by depth
// [RULE19] Dual-port read and write widths differ
// [RULE20] No match: flag low, lines low
// [RULE21] Encoded multiple reports lowest matching word
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "emb_cfg.svh"

module emb_memory_block
	import emb_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              global_clear,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [1:0]        port_in_en,
	input  wire logic [1:0]        port_out_en,
	input  wire logic [1:0]        port_clear,
	input  wire logic [1:0]        port_write_request,
	input  wire logic [1:0]        read_strobe,
	input  wire logic [1:0][11:0]  port_waddr,
	input  wire logic [1:0][11:0]  port_raddr,
	input  wire logic [1:0][15:0]  port_wdata,
	output logic      [1:0][15:0]  port_rdata,
	input  wire logic              cam_write,
	input  wire logic [4:0]        cam_write_addr,
	input  wire logic [31:0]       cam_write_data,
	input  wire logic [31:0]       cam_write_care,
	input  wire logic              cam_write_care_en,
	input  wire logic              cam_lookup,
	input  wire logic [31:0]       cam_key,
	output logic                   cam_busy,
	output logic                   cam_valid,
	output logic                   cam_phase,
	output logic                   cam_match,
	output logic      [4:0]        cam_match_addr,
	output logic      [15:0]       cam_lines
);

	emb_state_t s_r;
	emb_state_t s_nxt;
	logic [1:0] rst_q_r;
	logic       rst_n;

	logic [1:0][15:0] eff_wd;
	logic [1:0][11:0] eff_wa;
	logic [1:0][11:0] eff_ra;
	logic [1:0]       eff_we;
	logic [1:0]       eff_re;
	logic [1:0]       clr;
	logic [31:0]      hit;
	logic [31:0]      cmp_mask;
	logic             wb_req;

	// Lowest set bit of a hit vector with a found flag
	function automatic logic [5:0] emb_prio(input logic [31:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 31; i >= 0; i--)
			if (v[i])
				r = {1'b1, 5'(i)};
		return r;
	endfunction

	// Port width in bits; ROM has no 16-bit shape
	function automatic logic [4:0] emb_width(input logic [2:0] sel, input emb_mode_t m);
		logic [2:0] k;
		k = (sel > `EMB_MAX_WSEL) ? `EMB_MAX_WSEL : sel;
		if (m == EMB_ROM && k > `EMB_ROM_WSEL)
			k = `EMB_ROM_WSEL;
		return 5'(5'h01 << k);
	endfunction

	// Bit offset of a port word; split mode confines each port to its half
	function automatic logic [11:0] emb_offset(input logic [11:0] a, input logic [2:0] sel,
			input emb_mode_t m, input logic p);
		logic [15:0] o;
		logic [2:0]  k;
		k = (sel > `EMB_MAX_WSEL) ? `EMB_MAX_WSEL : sel;
		if (m == EMB_ROM && k > `EMB_ROM_WSEL)
			k = `EMB_ROM_WSEL;
		o = 16'({4'h0, a} << k);
		if (m == EMB_SPLIT)
			o = {4'h0, p, o[10:0]};
		return o[11:0];
	endfunction

	// Reset release through two flops
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rst_q_r <= 2'h0;
		else
			rst_q_r <= {rst_q_r[0], 1'b1};
	end
	assign rst_n = rst_q_r[1];

	// Each input path picks its input register or the live pin
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_port
			assign clr[gp]    = port_clear[gp] | global_clear; // RULE2
			assign eff_wd[gp] = s_r.opts[`EMB_OPT_WDATA] ? s_r.wd[gp] : port_wdata[gp]; // RULE16
			assign eff_wa[gp] = s_r.opts[`EMB_OPT_WADDR] ? s_r.wa[gp] : port_waddr[gp]; // RULE16
			assign eff_ra[gp] = s_r.opts[`EMB_OPT_RADDR] ? s_r.ra[gp] : port_raddr[gp]; // RULE16
			assign eff_we[gp] = s_r.opts[`EMB_OPT_WE] ? s_r.we[gp] : port_write_request[gp];
			assign eff_re[gp] = s_r.opts[`EMB_OPT_RE] ? s_r.re[gp] : read_strobe[gp];
			// Clear blanks the output at once, without waiting for an edge
			assign port_rdata[gp] = clr[gp] ? 16'h0000 :
				(s_r.opts[`EMB_OPT_RDATA] ? s_r.rd2[gp] : s_r.rd1[gp]); // RULE3
		end
	endgenerate

	// Unencoded lookups give up bit 0 to the bank select
	assign cmp_mask = s_r.enc ? 32'hFFFF_FFFF : 32'hFFFF_FFFE; // RULE10

	// All 32 words compared in parallel against the live key
	genvar gw;
	generate
		for (gw = 0; gw < `EMB_CAM_WORDS; gw++)
		begin : g_word
			assign hit[gw] = (((s_r.mem[gw*32 +: 32] ^ cam_key) & cmp_mask
				& ~s_r.care[gw*32 +: 32]) == 32'h0000_0000)
				&& !(s_r.cmode == EMB_FAST && gw >= `EMB_FAST_WORDS); // RULE5 RULE7 RULE14
		end
	endgenerate

	assign wb_req = wb_cyc_i & wb_stb_i & ~s_r.ack;

	// Next state of the whole block
	always_comb
	begin
		logic [11:0] off;
		logic [4:0]  w;
		logic [15:0] rw;
		logic [5:0]  pr;
		logic [15:0] lines;
		off   = 12'h000;
		w     = 5'h00;
		rw    = 16'h0000;
		pr    = 6'h00;
		lines = 16'h0000;
		s_nxt = s_r;
		s_nxt.valid = 1'b0;

		// Wishbone: answer one cycle after the request, drop ack after one cycle
		s_nxt.ack = wb_req;
		if (wb_req)
		begin
			s_nxt.dat = 32'h0000_0000;
			unique case (wb_adr_i)
				`EMB_ADR_CTRL:
				begin
					s_nxt.dat = {21'h0, s_r.enc, s_r.cmode, s_r.wsel[1], s_r.wsel[0], s_r.mode};
					if (wb_we_i && wb_sel_i[0])
					begin
						s_nxt.mode    = emb_mode_t'(wb_dat_i[`EMB_CTRL_MODE_LSB +: 2]);
						s_nxt.wsel[0] = wb_dat_i[`EMB_CTRL_WSELA_LSB +: 3];
						// Both width selects sit wholly in byte lane 0
						s_nxt.wsel[1] = wb_dat_i[`EMB_CTRL_WSELB_LSB +: 3];
					end
					if (wb_we_i && wb_sel_i[1])
					begin
						s_nxt.cmode = emb_cmode_t'(wb_dat_i[`EMB_CTRL_CMODE_LSB +: 2]); // RULE8
						s_nxt.enc   = wb_dat_i[`EMB_CTRL_ENC_BIT];
					end
				end
				`EMB_ADR_OPTS:
				begin
					s_nxt.dat = {26'h0, s_r.opts};
					if (wb_we_i && wb_sel_i[0])
						s_nxt.opts = wb_dat_i[5:0]; // RULE16
				end
				`EMB_ADR_STATUS:
					s_nxt.dat = {23'h0, s_r.phase, s_r.maddr, s_r.match, s_r.pend,
						s_r.cw != EMB_CW_IDLE};
				`EMB_ADR_LOAD_ADDR:
				begin
					s_nxt.dat = {24'h0, s_r.ld_idx};
					if (wb_we_i && wb_sel_i[0])
						s_nxt.ld_idx = wb_dat_i[7:0];
				end
				`EMB_ADR_LOAD_DATA:
				begin
					// Configuration-time loading; the index steps on every write
					s_nxt.dat = {16'h0, s_r.mem[{s_r.ld_idx, 4'h0} +: 16]};
					if (wb_we_i)
					begin
						if (wb_sel_i[0])
							s_nxt.mem[{s_r.ld_idx, 4'h0} +: 8] = wb_dat_i[7:0]; // RULE17 RULE15
						if (wb_sel_i[1])
							s_nxt.mem[{s_r.ld_idx, 4'h8} +: 8] = wb_dat_i[15:8];
						s_nxt.ld_idx = s_r.ld_idx + 8'h01;
					end
				end
				`EMB_ADR_LINES:
					s_nxt.dat = {16'h0, s_r.lines};
				default:
					s_nxt.dat = 32'h0000_0000;
			endcase
		end

		// Port input registers load on the input enable only
		for (int p = 0; p < 2; p++)
		begin
			if (port_in_en[p])
			begin
				s_nxt.wd[p] = port_wdata[p]; // RULE1
				s_nxt.wa[p] = port_waddr[p];
				s_nxt.ra[p] = port_raddr[p];
				s_nxt.we[p] = port_write_request[p];
				s_nxt.re[p] = read_strobe[p];
			end
			// Port writes; a ROM or match table ignores them
			w = emb_width(s_r.wsel[p], s_r.mode); // RULE18 RULE19
			if (port_in_en[p] && eff_we[p] && !clr[p]
				&& (s_r.mode == EMB_DUAL || s_r.mode == EMB_SPLIT)) // RULE17
			begin
				off = emb_offset(eff_wa[p], s_r.wsel[p], s_r.mode, p[0]); // RULE4
				for (int i = 0; i < 16; i++)
					if (5'(i) < w)
						s_nxt.mem[off + 12'(i)] = eff_wd[p][i];
			end
			// Reads go through the output registers on the output enable
			off = emb_offset(eff_ra[p], s_r.wsel[p], s_r.mode, p[0]);
			rw  = 16'(s_r.mem >> off) & 16'((17'h00001 << w) - 17'h00001);
			if (port_out_en[p])
			begin
				if (eff_re[p])
					s_nxt.rd1[p] = rw; // RULE1
				s_nxt.rd2[p] = s_r.rd1[p]; // RULE16
			end
			// Local or global clear empties this port's registers
			if (clr[p])
			begin
				s_nxt.wd[p]  = 16'h0000; // RULE3
				s_nxt.wa[p]  = 12'h000;
				s_nxt.ra[p]  = 12'h000;
				s_nxt.we[p]  = 1'b0;
				s_nxt.re[p]  = 1'b0;
				s_nxt.rd1[p] = 16'h0000;
				s_nxt.rd2[p] = 16'h0000;
			end
		end

		// Match-table write: two cycles, a third for don't-care bits
		unique case (s_r.cw)
			EMB_CW_IDLE:
				if (cam_write && s_r.mode == EMB_CAM)
				begin
					s_nxt.cw         = EMB_CW_DATA; // RULE15
					s_nxt.cw_addr    = (s_r.cmode == EMB_FAST) ? {1'b0, cam_write_addr[3:0]}
						: cam_write_addr; // RULE14
					s_nxt.cw_data    = cam_write_data;
					s_nxt.cw_care    = cam_write_care;
					s_nxt.cw_care_en = cam_write_care_en;
				end
			EMB_CW_DATA:
				s_nxt.cw = EMB_CW_COMMIT;
			EMB_CW_COMMIT:
			begin
				s_nxt.mem[{s_r.cw_addr, 5'h00} +: 32] = s_r.cw_data; // RULE6 RULE12 RULE13
				if (!s_r.cw_care_en)
					s_nxt.care[{s_r.cw_addr, 5'h00} +: 32] = 32'h0000_0000;
				s_nxt.cw = s_r.cw_care_en ? EMB_CW_CARE : EMB_CW_IDLE;
			end
			EMB_CW_CARE:
			begin
				s_nxt.care[{s_r.cw_addr, 5'h00} +: 32] = s_r.cw_care; // RULE7 RULE15
				s_nxt.cw = EMB_CW_IDLE;
			end
		endcase

		// Lookups: results registered one edge after the request
		if (s_r.pend)
		begin
			// Second half of a multiple-match report: odd words
			for (int i = 0; i < 16; i++)
				lines[i] = s_r.hits[2*i+1]; // RULE13
			s_nxt.lines = s_r.enc ? 16'h0000 : lines;
			s_nxt.phase = 1'b1;
			s_nxt.valid = 1'b1;
			s_nxt.pend  = 1'b0;
		end
		else if (cam_lookup && s_r.mode == EMB_CAM)
		begin
			pr = emb_prio(hit); // RULE21
			s_nxt.hits  = hit;
			s_nxt.valid = 1'b1;
			s_nxt.phase = 1'b0;
			s_nxt.match = pr[5]; // RULE20
			s_nxt.maddr = pr[4:0];
			unique case (s_r.cmode)
				EMB_SINGLE:
					for (int i = 0; i < 16; i++)
						lines[i] = hit[2*i + int'(cam_key[0])]; // RULE9 RULE11 RULE12
				EMB_MULTI:
				begin
					for (int i = 0; i < 16; i++)
						lines[i] = hit[2*i]; // RULE13
					s_nxt.pend = 1'b1;
				end
				EMB_FAST:
					lines = hit[15:0]; // RULE14
				default:
					lines = 16'h0000;
			endcase
			if (!s_r.enc && s_r.cmode == EMB_SINGLE)
			begin
				s_nxt.match = |lines; // RULE5
				pr = emb_prio({16'h0000, lines});
				s_nxt.maddr = {pr[3:0], cam_key[0]};
			end
			s_nxt.lines = s_r.enc ? 16'h0000 : lines; // RULE20
		end
	end

	// One register bank for the whole block
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r        <= '0; // RULE3
			s_r.mode   <= emb_mode_t'(2'(`EMB_CTRL_RST));
			s_r.opts   <= `EMB_OPTS_RST;
			s_r.cmode  <= EMB_SINGLE;
			s_r.cw     <= EMB_CW_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	assign wb_dat_o       = s_r.dat;
	assign wb_ack_o       = s_r.ack;
	assign cam_busy       = s_r.cw != EMB_CW_IDLE;
	assign cam_valid      = s_r.valid;
	assign cam_phase      = s_r.phase;
	assign cam_match      = s_r.match;
	assign cam_match_addr = s_r.maddr;
	assign cam_lines      = s_r.lines;

endmodule

// >>> emb_asserts.sv
`timescale 1ns/1ps
// Port checks on the bus, the port clears and the match engine
module emb_asserts (
	input wire logic             clock,
	input wire logic             arst_n,
	input wire logic             global_clear,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_ack_o,
	input wire logic [1:0]       port_clear,
	input wire logic [1:0][15:0] port_rdata,
	input wire logic             cam_write,
	input wire logic             cam_busy,
	input wire logic             cam_lookup,
	input wire logic             cam_valid,
	input wire logic             cam_phase,
	input wire logic             cam_match,
	input wire logic [4:0]       cam_match_addr,
	input wire logic [15:0]      cam_lines
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Any clear may legally disturb the held results
	wire clr = global_clear || (|port_clear);
	// A table write keeps busy two cycles, three when masks are written
	sequence s_wr2;
		cam_busy [*2] ##1 !cam_busy;
	endsequence
	sequence s_wr3;
		cam_busy [*3] ##1 !cam_busy;
	endsequence
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	busy_span_a: assert property ($rose(cam_busy) |-> s_wr2 or s_wr3)
		else $error("table write length wrong");
	busy_cause_a: assert property ($rose(cam_busy) |-> $past(cam_write))
		else $error("busy without a write");
	valid_cause_a: assert property (cam_valid && !cam_phase |-> $past(cam_lookup))
		else $error("result without a lookup");
	phase_order_a: assert property (cam_valid && cam_phase |-> $past(cam_valid && !cam_phase))
		else $error("second phase out of order");
	miss_lines_a: assert property (cam_valid && !cam_match |-> cam_lines == 16'h0000)
		else $error("lines set without a match");
	result_hold_a: assert property (!cam_valid && !clr && !$past(clr) |->
		$stable({cam_match, cam_match_addr, cam_lines}))
		else $error("results changed without a lookup");
	port_clear_a: assert property (port_clear[1] |-> port_rdata[1] == 16'h0000)
		else $error("local clear left read data");
	chip_clear_a: assert property (global_clear |-> port_rdata == 32'h0000_0000)
		else $error("global clear left read data");
endmodule

// >>> emb_fabric_model.sv
`timescale 1ns/1ps
// Fabric logic that loads and searches the match table
module emb_fabric_model (
	input  wire logic        clock,
	input  wire logic        cam_busy,
	output logic             cam_write,
	output logic [4:0]       cam_write_addr,
	output logic [31:0]      cam_write_data,
	output logic [31:0]      cam_write_care,
	output logic             cam_write_care_en,
	output logic             cam_lookup,
	output logic [31:0]      cam_key
);
	// Idle values at time zero
	initial
	begin
		{cam_write, cam_write_care_en, cam_lookup} = 3'h0;
		cam_write_addr = 5'h00;
		{cam_write_data, cam_write_care, cam_key} = 96'h0;
	end
	// One word; waits out busy, since a write during busy is dropped
	task automatic write_word(input logic [4:0] ad, input logic [31:0] dv, input logic [31:0] m);
		int n;
		@(posedge clock);
		cam_write <= 1'b1;
		cam_write_addr <= ad;
		cam_write_data <= dv;
		cam_write_care <= m;
		cam_write_care_en <= |m;
		@(posedge clock);
		cam_write <= 1'b0;
		cam_write_data <= ~dv;
		#1;
		n = 0;
		while (cam_busy && n < 8)
		begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask
	// Key is live only at the taking edge, scrambled afterwards
	task automatic search(input logic [31:0] kv);
		@(posedge clock);
		cam_lookup <= 1'b1;
		cam_key <= kv;
		@(posedge clock);
		cam_lookup <= 1'b0;
		cam_key <= ~kv;
	endtask
endmodule

// >>> emb_memory_block_tb_top.sv
`timescale 1ns/1ps
`include "emb_cfg.svh"
// Self-checking bench for the memory and match block
module emb_memory_block_tb_top;
	logic             clock, arst_n, global_clear, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [7:0]       wb_adr_i, a;
	logic [3:0]       wb_sel_i;
	logic [31:0]      wb_dat_i, wb_dat_o, rd, k, h, tbl [32], dc [32];
	logic [1:0]       port_in_en, port_out_en, port_clear, port_write_request, read_strobe;
	logic [1:0][11:0] port_waddr, port_raddr;
	logic [1:0][15:0] port_wdata, port_rdata;
	logic             cam_write, cam_write_care_en, cam_lookup, cam_busy, cam_valid;
	logic             cam_phase, cam_match;
	logic [4:0]       cam_write_addr, cam_match_addr;
	logic [31:0]      cam_write_data, cam_write_care, cam_key;
	logic [15:0]      cam_lines, d, e;
	int               failures = 0;
	int               comparisons = 0;
	int               j;
	// Match-table settings: single, encoded single, multi, encoded multi, fast encoded, fast lines
	localparam logic [31:0] ctrl_modes [6] = '{32'h0000_0003, 32'h0000_0403,
		32'h0000_0103, 32'h0000_0503, 32'h0000_0603, 32'h0000_0203};

	emb_memory_block u_emb_memory_block (
		.clock, .arst_n, .global_clear, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .port_in_en, .port_out_en,
		.port_clear, .port_write_request, .read_strobe, .port_waddr, .port_raddr,
		.port_wdata, .port_rdata, .cam_write, .cam_write_addr, .cam_write_data,
		.cam_write_care, .cam_write_care_en, .cam_lookup, .cam_key, .cam_busy,
		.cam_valid, .cam_phase, .cam_match, .cam_match_addr, .cam_lines
	);
	emb_fabric_model u_emb_fabric_model (
		.clock, .cam_busy, .cam_write, .cam_write_addr, .cam_write_data,
		.cam_write_care, .cam_write_care_en, .cam_lookup, .cam_key
	);

	// 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Expected hit vector; masked bits and ignored bits never decide
	function automatic logic [31:0] hits(input logic [31:0] kv, input logic [31:0] ign, input int nw);
		hits = 32'h0000_0000;
		for (int i = 0; i < nw; i++)
			hits[i] = ((tbl[i] ^ kv) & ~dc[i] & ~ign) == 32'h0000_0000;
	endfunction
	function automatic logic [4:0] low(input logic [31:0] hv);
		low = 5'h00;
		for (int i = 31; i >= 0; i--)
			if (hv[i])
				low = 5'(i);
	endfunction
	function automatic logic [15:0] lines(input logic [31:0] hv, input logic s);
		for (int i = 0; i < 16; i++)
			lines[i] = hv[2 * i + s];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] q);
		int t;
		logic ack_s;
		@(posedge clock);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= ad;
		wb_dat_i <= wd;
		t = 0;
		// Ack and data read mid-cycle are what the next rising edge samples
		do
		begin
			@(negedge clock);
			ack_s = wb_ack_o;
			q = wb_dat_o;
			@(posedge clock);
			t++;
		end
		while (ack_s !== 1'b1 && t < 20);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		if (t >= 20)
			failures++;
	endtask
	// Cuts a hang short
	initial
	begin
		repeat (5000) @(posedge clock);
		failures++;
		wrap_up();
	end
	// Main sequence: registers, match table, then the ports
	initial
	begin
		{arst_n, global_clear, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h00;
		{wb_adr_i, wb_dat_i, wb_sel_i} = 44'h0000_0000_00F;
		{port_in_en, port_out_en, port_clear, port_write_request, read_strobe} = 10'h000;
		{port_waddr, port_raddr, port_wdata} = 80'h0;
		void'($urandom(7));
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		wb(1'b0, `EMB_ADR_OPTS, 32'h0, rd);
		chk(rd, 32'h0000_003D);
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd);
		wb(1'b0, 8'h1C, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		wb(1'b1, `EMB_ADR_CTRL, ctrl_modes[0], rd);
		for (int i = 0; i < 32; i++)
		begin
			tbl[i] = (i == 19) ? tbl[6] : $urandom;
			dc[i] = (i == 9) ? 32'h00FF_0000 : 32'h0;
			u_emb_fabric_model.write_word(5'(i), tbl[i], dc[i]);
		end
		for (int m = 0; m < 6; m++)
		begin
			wb(1'b1, `EMB_ADR_CTRL, ctrl_modes[m], rd);
			wb(1'b0, `EMB_ADR_CTRL, 32'h0, rd);
			chk(rd, ctrl_modes[m]);
			for (int r = 0; r < 6; r++)
			begin
				j = (r == 0) ? 9 : $urandom % 32;
				k = (r == 5) ? $urandom : tbl[j] ^ ($urandom & dc[j]);
				h = hits(k, {31'h0, !ctrl_modes[m][10]}, ctrl_modes[m][9] ? 16 : 32);
				u_emb_fabric_model.search(k);
				#1;
				chk({cam_valid, cam_phase}, 2'h2);
				if (ctrl_modes[m][10])
				begin
					chk(cam_match, |h);
					if (|h)
						chk(cam_match_addr, low(h));
				end
				else
				begin
					e = (m == 5) ? h[15:0] : lines(h, m == 2 ? 1'b0 : k[0]);
					chk(cam_lines, e);
					if (m == 0)
						chk(cam_match, |e);
					if (m == 5)
					begin
						wb(1'b0, `EMB_ADR_LINES, 32'h0, rd);
						chk(rd, {16'h0000, e});
					end
				end
				if (m == 2 || m == 3)
				begin
					@(posedge clock);
					#1;
					chk({cam_valid, cam_phase}, 2'h3);
					if (m == 2)
						chk(cam_lines, lines(h, 1'b1));
				end
			end
		end
		// Dual port: 16-bit writes on A, 1-bit reads on B, no path registers
		wb(1'b1, `EMB_ADR_CTRL, 32'h0000_0010, rd);
		wb(1'b1, `EMB_ADR_OPTS, 32'h0, rd);
		{port_in_en, port_out_en} <= 4'hF;
		for (int r = 0; r < 3; r++)
		begin
			a = 8'($urandom);
			d = 16'($urandom) | 16'h8000;
			@(posedge clock);
			port_write_request <= 2'h1;
			port_waddr[0] <= {4'h0, a};
			port_wdata[0] <= d;
			@(posedge clock);
			port_write_request <= 2'h0;
			for (int b = 0; b < 16; b++)
			begin
				@(posedge clock);
				port_raddr[1] <= {a, 4'(b)};
				read_strobe <= 2'h2;
				@(posedge clock);
				#1;
				chk(port_rdata[1], {15'h0, d[b]});
			end
		end
		@(posedge clock);
		port_clear <= 2'h2;
		port_raddr[0] <= {4'h0, a};
		read_strobe <= 2'h1;
		@(posedge clock);
		#1;
		chk(port_rdata, {16'h0000, d});
		@(posedge clock);
		global_clear <= 1'b1;
		port_clear <= 2'h0;
		@(posedge clock);
		#1;
		chk(port_rdata, 32'h0000_0000);
		// Split halves: one address on both ports lands in two places
		@(posedge clock);
		global_clear <= 1'b0;
		wb(1'b1, `EMB_ADR_CTRL, 32'h0000_006D, rd);
		port_write_request <= 2'h3;
		port_waddr <= {12'h011, 12'h011};
		port_wdata <= {~d, d};
		port_raddr <= {12'h011, 12'h011};
		read_strobe <= 2'h3;
		@(posedge clock);
		port_write_request <= 2'h0;
		@(posedge clock);
		#1;
		chk(port_rdata, {8'h00, ~d[7:0], 8'h00, d[7:0]});
		// ROM: loaded over the bus, port writes refused
		wb(1'b1, `EMB_ADR_LOAD_ADDR, 32'h0000_0055, rd);
		wb(1'b1, `EMB_ADR_LOAD_DATA, {16'h0000, d}, rd);
		wb(1'b0, `EMB_ADR_LOAD_ADDR, 32'h0, rd);
		chk(rd, 32'h0000_0056);
		wb(1'b1, `EMB_ADR_CTRL, 32'h0000_000E, rd);
		port_write_request <= 2'h1;
		port_waddr[0] <= 12'h0AA;
		port_wdata[0] <= ~d;
		port_raddr[0] <= 12'h0AA;
		read_strobe <= 2'h1;
		@(posedge clock);
		port_write_request <= 2'h0;
		port_raddr[0] <= 12'h0AB;
		#1;
		chk(port_rdata[0], {8'h00, d[7:0]});
		@(posedge clock);
		port_raddr[0] <= 12'h0AA;
		#1;
		chk(port_rdata[0], {8'h00, d[15:8]});
		@(posedge clock);
		#1;
		chk(port_rdata[0], {8'h00, d[7:0]});
		wrap_up();
	end
endmodule

bind emb_memory_block emb_asserts u_emb_asserts (
	.clock, .arst_n, .global_clear, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .port_clear,
	.port_rdata, .cam_write, .cam_busy, .cam_lookup, .cam_valid, .cam_phase,
	.cam_match, .cam_match_addr, .cam_lines
);
